/* File: rtl/edc_divider.v */
// Edge clock divider: source select, divide by 2, 4 or 8, reset and release.
//
// What this block does
// - The output runs at a half, a quarter or an eighth of the selected input clock as the mode says.
// - The output phase is fixed by the first edge of the selected input clock after release, so every restart gives the same phase.
// - The divider reset clears the divider and drives all outputs low at once, with no clock edge.
// - After release is asserted the outputs start toggling only on an edge of the input clock.
// - The input clock is chosen among a PLL or DLL output, a delay line, a fabric signal or a pin.
`timescale 1ns/1ps
`default_nettype none

`include "edc_map.vh"

module edc_divider (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_div_rst,
  input wire i_release,
  input wire [1:0] i_div_mode,
  input wire [1:0] i_src_sel,
  input wire i_src_pll,
  input wire i_src_delay,
  input wire i_src_fabric,
  input wire i_src_ext,
  output reg o_div_clk,
  output reg o_div2,
  output reg o_div4,
  output reg o_div8,
  output reg o_running
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  wire pll_level;
  wire delay_level;
  wire fabric_level;
  wire ext_level;
  wire release_level;

  edc_sync u_sync_pll (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_src_pll),
    .o_level(pll_level)
  );

  edc_sync u_sync_delay (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_src_delay),
    .o_level(delay_level)
  );

  edc_sync u_sync_fabric (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_src_fabric),
    .o_level(fabric_level)
  );

  edc_sync u_sync_ext (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_src_ext),
    .o_level(ext_level)
  );

  edc_sync u_sync_release (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async(i_release),
    .o_level(release_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Divider reset release.

  // The divider reset clears all but the input synchronisers at once, but its release is just
  // as asynchronous as its assertion. Three stages move the release onto
  // the clock, and the core leaves clear only when the second and third
  // agree, so the counter never starts inside a metastable window.
  reg div_hold1;
  reg div_hold2;
  reg div_hold3;
  wire core_clear;

  always @(posedge i_clock or posedge i_div_rst) begin
    if (i_div_rst) begin
      div_hold1 <= `EDC_HIGH;
      div_hold2 <= `EDC_HIGH;
      div_hold3 <= `EDC_HIGH;
    end else begin
      div_hold1 <= `EDC_LOW;
      div_hold2 <= div_hold1;
      div_hold3 <= div_hold2;
    end
  end

  // The system reset joins the same clear, so both resets release the
  // counter and the outputs through one path.
  assign core_clear = !i_rst_n || div_hold2 || div_hold3;

  ////////////////////////////////////////////////////////////////////////////
  // Source edge detection and selection.

  // One previous-level flop per source, so that moving the selector picks
  // up a real edge of the new source rather than a step between sources.
  // The counter is held in clear while the divider reset is released,
  // which masks the one false edge that the cleared flops can show.
  // Limitation: a source level must stand for about two clock cycles to
  // pass the filter, so a faster source loses edges and the output slows.
  reg pll_prev;
  reg delay_prev;
  reg fabric_prev;
  reg ext_prev;
  reg src_edge;

  always @(posedge i_clock or posedge i_div_rst) begin
    if (i_div_rst) begin
      pll_prev <= `EDC_LOW;
      delay_prev <= `EDC_LOW;
      fabric_prev <= `EDC_LOW;
      ext_prev <= `EDC_LOW;
    end else begin
      pll_prev <= pll_level;
      delay_prev <= delay_level;
      fabric_prev <= fabric_level;
      ext_prev <= ext_level;
    end
  end

  always @* begin
    case (i_src_sel)
      `EDC_SRC_PLL: src_edge = pll_level & ~pll_prev;
      `EDC_SRC_DELAY: src_edge = delay_level & ~delay_prev;
      `EDC_SRC_FABRIC: src_edge = fabric_level & ~fabric_prev;
      `EDC_SRC_EXT: src_edge = ext_level & ~ext_prev;
      default: src_edge = pll_level & ~pll_prev;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Division counter and output clock select.

  reg running;
  reg next_running;
  reg [`EDC_CNT_W-1:0] cnt;
  reg [`EDC_CNT_W-1:0] next_cnt;
  reg next_div_clk;

  always @* begin
    next_running = running;
    next_cnt = cnt;
    if (src_edge) begin
      if (running) begin
        next_cnt = cnt + `EDC_CNT_ONE;
      end else if (release_level) begin
        // Start counts from one on this edge, so the phase repeats.
        next_running = `EDC_HIGH;
        next_cnt = `EDC_CNT_ONE;
      end
    end
  end

  // Mode code 3 is not a division of its own; it falls back to halving.
  always @* begin
    case (i_div_mode)
      `EDC_MODE_DIV2: next_div_clk = next_cnt[`EDC_BIT_DIV2];
      `EDC_MODE_DIV4: next_div_clk = next_cnt[`EDC_BIT_DIV4];
      `EDC_MODE_DIV8: next_div_clk = next_cnt[`EDC_BIT_DIV8];
      default: next_div_clk = next_cnt[`EDC_BIT_DIV2];
    endcase
  end

  // Both resets clear the counter; the divider reset acts with no clock.
  always @(posedge i_clock or posedge i_div_rst) begin
    if (i_div_rst) begin
      running <= `EDC_LOW;
      cnt <= `EDC_CNT_RST;
    end else if (core_clear) begin
      running <= `EDC_LOW;
      cnt <= `EDC_CNT_RST;
    end else begin
      running <= next_running;
      cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // Each divided output is a flop fed from the next counter value, so it moves on
  // the same clock edge as the counter and cannot glitch between edges.
  // The trade is the adder path standing in front of the output flops.
  always @(posedge i_clock or posedge i_div_rst) begin
    if (i_div_rst) begin
      o_div_clk <= `EDC_LOW;
      o_div2 <= `EDC_LOW;
      o_div4 <= `EDC_LOW;
      o_div8 <= `EDC_LOW;
      o_running <= `EDC_LOW;
    end else if (core_clear) begin
      o_div_clk <= `EDC_LOW;
      o_div2 <= `EDC_LOW;
      o_div4 <= `EDC_LOW;
      o_div8 <= `EDC_LOW;
      o_running <= `EDC_LOW;
    end else begin
      o_div_clk <= next_div_clk;
      o_div2 <= next_cnt[`EDC_BIT_DIV2];
      o_div4 <= next_cnt[`EDC_BIT_DIV4];
      o_div8 <= next_cnt[`EDC_BIT_DIV8];
      o_running <= next_running;
    end
  end

endmodule // edc_divider

`default_nettype wire

/* File: rtl/edc_map.vh */
// Named constants for the edge clock divider.
`ifndef EDC_MAP_VH
`define EDC_MAP_VH

// Division modes on i_div_mode.
`define EDC_MODE_DIV2 2'h0
`define EDC_MODE_DIV4 2'h1
`define EDC_MODE_DIV8 2'h2

// Input clock sources on i_src_sel.
`define EDC_SRC_PLL 2'h0
`define EDC_SRC_DELAY 2'h1
`define EDC_SRC_FABRIC 2'h2
`define EDC_SRC_EXT 2'h3

// Division counter width, its reset value and one step.
`define EDC_CNT_W 3
`define EDC_CNT_RST 3'h0
`define EDC_CNT_ONE 3'h1

// Bit of the counter that carries each divided clock.
`define EDC_BIT_DIV2 0
`define EDC_BIT_DIV4 1
`define EDC_BIT_DIV8 2

// Reset level of every synchroniser stage and of every output.
`define EDC_LOW 1'h0

// Held level of the divider reset stages and of the start flag.
`define EDC_HIGH 1'h1

`endif

/* File: rtl/edc_sync.v */
// Three-stage synchroniser with a two-stage agreement filter.
`timescale 1ns/1ps
`default_nettype none

`include "edc_map.vh"

module edc_sync (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_async,
  output reg o_level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // Only stage2 reads stage1; the filter looks at stages two and three.
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      stage1 <= `EDC_LOW;
      stage2 <= `EDC_LOW;
      stage3 <= `EDC_LOW;
      o_level <= `EDC_LOW;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        o_level <= stage3;
      end
    end
  end

endmodule // edc_sync

`default_nettype wire

/* File: tb/edc_divider_properties.sv */
// Port assertions for the edge clock divider.
`timescale 1ns/1ps
`default_nettype none
module edc_props (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_div_rst,
  input wire logic i_release,
  input wire logic [1:0] i_div_mode,
  input wire logic o_div_clk,
  input wire logic o_div2,
  input wire logic o_div4,
  input wire logic o_div8,
  input wire logic o_running
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n || i_div_rst);
  wire logic up = o_div2 | o_div4 | o_div8 | o_div_clk;
  sequence s_go;
    $rose(o_running);
  endsequence
  AST_DIV4: assert property (o_running && $past(o_running)
    && $changed(o_div4) |-> $fell(o_div2)) else $error("div4");
  AST_FIRST: assert property (s_go |-> o_div2 && !o_div4 && !o_div8)
    else $error("first");
  // The divider reset is the cause here, so only the system reset disables.
  AST_CLEAR: assert property (disable iff (!i_rst_n)
    i_div_rst |-> !up && !o_running) else $error("clear");
  AST_SYNC: assert property (s_go |-> $past(i_release, 3))
    else $error("sync");
  AST_IDLE: assert property (!o_running |-> !up)
    else $error("idle");
  sequence s_steady;
    o_running && $past(o_running);
  endsequence
  AST_DIV8: assert property (s_steady ##0 $changed(o_div8)
    |-> $fell(o_div4)) else $error("div8");
  AST_SEL4: assert property (s_steady ##0 $past(i_div_mode) == 2'h1
    |-> o_div_clk == o_div4) else $error("sel4");
  AST_SEL8: assert property (s_steady ##0 $past(i_div_mode) == 2'h2
    |-> o_div_clk == o_div8) else $error("sel8");
endmodule // edc_props
bind edc_divider edc_props u_props (.*);
`default_nettype wire

/* File: tb/edc_src_model.sv */
// Free-running source clocks, one rate per source.
`timescale 1ns/1ps
`default_nettype none
module edc_src_model (
  output logic [3:0] o_src
);
  // One process owns the whole vector; the sources toggle every four,
  // five, six or seven system clock periods, at a falling clock edge.
  int unsigned tick = 0;
  initial begin
    o_src = 4'h0;
    forever begin
      #10;
      tick++;
      o_src = {tick % 14 >= 7, tick % 12 >= 6, tick % 10 >= 5, tick % 8 >= 4};
    end
  end
endmodule // edc_src_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the edge clock divider.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clock, i_rst_n, i_div_rst, i_release, v;
  logic [1:0] i_div_mode, i_src_sel;
  wire logic i_src_pll, i_src_delay, i_src_fabric, i_src_ext;
  wire logic o_div_clk, o_div2, o_div4, o_div8, o_running;
  int mismatches, n_checks, cyc, k, n;
  logic [31:0] lfsr = 32'h74a7_75ac;
  edc_src_model src (
    .o_src({i_src_ext, i_src_fabric, i_src_delay, i_src_pll}));
  edc_divider uut (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_div_rst(i_div_rst),
    .i_release(i_release),
    .i_div_mode(i_div_mode),
    .i_src_sel(i_src_sel),
    .i_src_pll(i_src_pll),
    .i_src_delay(i_src_delay),
    .i_src_fabric(i_src_fabric),
    .i_src_ext(i_src_ext),
    .o_div_clk(o_div_clk),
    .o_div2(o_div2),
    .o_div4(o_div4),
    .o_div8(o_div8),
    .o_running(o_running)
  );
  function logic [31:0] step(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(logic [7:0] seen, want);
    n_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t got %0d want %0d", $time, seen, want);
    end
  endtask
  task conclude;
    if (cyc >= 9000) mismatches++;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (++cyc == 9000) conclude();
  initial begin
    {i_rst_n, i_div_rst, i_release, i_div_mode, i_src_sel} = 7'h00;
    repeat (16) @(negedge i_clock);
    i_rst_n = 1'h1;
    for (k = 0; k < 16; k++) begin
      lfsr = step(lfsr);
      i_div_rst = 1'h1;
      i_release = 1'h0;
      {i_src_sel, i_div_mode} = k[3:0];
      #1 chk({o_div2, o_div4, o_div8, o_div_clk, o_running}, 8'h00);
      repeat (8 + lfsr[3:0]) @(negedge i_clock);
      i_div_rst = 1'h0;
      // Sources keep toggling here, so an early start would show.
      repeat (40 + lfsr[7:4]) @(negedge i_clock);
      chk({o_div2, o_div4, o_div8, o_div_clk, o_running}, 8'h00);
      i_release = 1'h1;
      for (n = 0; !o_running && n < 99; n++) @(negedge i_clock);
      chk(o_running, 8'h01);
      chk(o_div_clk, k % 4 % 3 == 0);
      for (int j = 0; j < 4; j++) begin
        v = o_div_clk;
        for (n = 0; o_div_clk === v && n < 99; n++) @(negedge i_clock);
        if (j > 0) chk(8'(n), 8'((2 << k % 4 % 3) * (k / 4 + 4)));
      end
      $display("test %0d done", k);
    end
    conclude();
  end
endmodule // tb_top
`default_nettype wire
